/* File: rtl/irq_front_pkg.sv */
// Constants and types shared by the interrupt front end
package irq_front_pkg;
    localparam int NUM_IRQ = 16;
    localparam logic [15:0] PROG_TRIG_MASK = 16'hcef8;
    localparam logic [15:0] HOLD_CHECK_MASK = 16'hcffa;
    localparam int KBD_LINE = 1;
    localparam int RTC_LINE = 8;
    localparam logic [3:0] DEFAULT_VECTOR = 4'h7;
    localparam logic [15:0] TRIG_RESET = 16'h0000;
    localparam int FLUSH_CYCLES_DEF = 4;
    typedef enum logic [1:0] {FL_IDLE, FL_FLUSH, FL_ACK} flush_state_t;
endpackage

/* File: rtl/sync2.sv */
// Two flip-flop level synchroniser, parameter width
`timescale 1ns/100ps
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk, // Clock
    input wire logic srst, // Synchronous reset
    input wire logic [WIDTH-1:0] d, // Asynchronous input
    output logic [WIDTH-1:0] q // Synchronised output
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s1_nxt;
    logic [WIDTH-1:0] q_nxt;
    always_comb begin
        s1_nxt = d;
        q_nxt = s1_r;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_r <= INIT;
            q <= INIT;
        end else begin
            s1_r <= s1_nxt;
            q <= q_nxt;
        end
    end
endmodule // sync2

/* File: rtl/legacy_irq_and_apic_handshake.sv */
// Legacy interrupt request front end and external I/O APIC handshake
// Functional notes
// - Flush request low starts buffer flush; acknowledge asserted only after flush finishes.
// - Flush acknowledge output is registered on the PCI-rate clock.
// - With controller in use, chip select low only when decode enabled and a PCI cycle hits the range.
// - Without external controller, handshake and timer pins are general-purpose I/O.
// - Timer output follows the system timer's request 0.
// - Keyboard request is rising-edge latched only, never level mode.
// - A request gone before acknowledge yields the default vector of line 7.
// - Lines 3-7, 9-11, 14-15 selectable edge or high level, edge after reset.
// - Clock request is active low, falling-edge latched, mode fixed.
// - Clock pin may be general input; with controller enabled it is an output.
// - Routed output carries SYSTEM_CONTROL_INTERRUPT and SMBus interrupts, else general-purpose output.
// - Acknowledge, select and routed outputs high in and after reset; timer low.
`timescale 1ns/100ps
module legacy_irq_and_apic_handshake
    import irq_front_pkg::*;
#(
    parameter int FLUSH_CYCLES = FLUSH_CYCLES_DEF
) (
    input wire logic sys_clk, // 100 MHz clock, PCI-rate domain
    input wire logic srst, // Synchronous reset, active high
    input wire logic ioapic_enable, // External interrupt controller in use
    input wire logic flush_request_n, // Flush request from controller, clock synchronous
    output logic flush_done_ack_n, // Flush acknowledge, active low
    output logic ioapic_select_n, // Controller chip select, active low
    output logic timer_irq_out, // Timer request 0 out
    output logic routed_sci_smbus_irq_n, // Routed SYSTEM_CONTROL_INTERRUPT/SMBus interrupt, active low
    input wire logic select_enable, // Chip select decode enabled
    input wire logic pci_cycle_valid, // PCI-originated cycle in progress
    input wire logic [31:0] pci_addr, // Address of that cycle
    input wire logic [31:0] ioapic_base, // Programmed range base
    input wire logic [31:0] ioapic_limit, // Programmed range last address
    output logic flush_start, // Pulse: start flushing buffers toward PCI
    input wire logic flush_buffers_empty, // Buffers toward PCI are empty
    input wire logic timer_timer_irq_out, // Internal timer request 0
    input wire logic system_control_interrupt, // Internal SYSTEM_CONTROL_INTERRUPT
    input wire logic smbus_irq, // Internal SMBus interrupt
    input wire logic gp_out_ack_alt, // General output value for acknowledge pin
    input wire logic gp_out_select_alt, // General output value for select pin
    input wire logic gp_out_timer_alt, // General output value for timer pin
    input wire logic gp_out_routed_alt, // General output value for routed pin
    output logic gp_in_request_alt, // General input read from request pin
    output logic gp_in_rtc_alt, // General input read from clock pin
    input wire logic rtc_gpi_select, // Software selects clock pin as general input
    input wire logic rtc_internal, // Internal real-time clock in use
    input wire logic rtc_irq_in_n, // Clock request pin input, active low
    output logic rtc_pin_out, // Clock pin output value
    output logic rtc_pin_oe_n, // Clock pin output enable, low drives
    input wire logic keyboard_irq_in, // Keyboard request pin
    input wire logic [NUM_IRQ-1:0] irq_in, // Other request pins, lines 3-7 9-11 14-15 used
    input wire logic [NUM_IRQ-1:0] level_mode, // 1 = high level sensitive per line
    input wire logic [NUM_IRQ-1:0] irq_enable, // Per-line enable
    input wire logic inta_pulse, // Interrupt acknowledge cycle pulse
    input wire logic [3:0] inta_line, // Line being acknowledged
    output logic cpu_intr, // Processor interrupt request
    output logic [3:0] inta_vector, // Line reported in acknowledge
    output logic inta_valid // Pulse: vector valid
);
    logic [NUM_IRQ-1:0] pins_raw;
    logic [NUM_IRQ-1:0] pins_s;
    logic flush_req_s;
    logic [NUM_IRQ-1:0] prev_r, prev_nxt;
    logic [NUM_IRQ-1:0] pend_r, pend_nxt;
    logic [NUM_IRQ-1:0] trig_r, trig_nxt;
    logic [NUM_IRQ-1:0] active;
    logic [NUM_IRQ-1:0] edge_hit;
    flush_state_t fl_r, fl_nxt;
    logic [7:0] fl_cnt_r, fl_cnt_nxt;
    logic ack_n_r, ack_n_nxt;
    logic sel_n_r, sel_n_nxt;
    logic tmr_r, tmr_nxt;
    logic rout_n_r, rout_n_nxt;
    logic start_r, start_nxt;
    logic [3:0] vec_r, vec_nxt;
    logic vval_r, vval_nxt;
    logic intr_r, intr_nxt;
    logic rtc_in_r, rtc_in_nxt;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Request pins are asynchronous; rtc line stored active high after inversion
    always_comb begin
        pins_raw = irq_in & PROG_TRIG_MASK;
        pins_raw[KBD_LINE] = keyboard_irq_in;
        pins_raw[RTC_LINE] = ~rtc_irq_in_n;
    end

    sync2 #(.WIDTH(NUM_IRQ), .INIT('0)) u_sync_irq (
        .sys_clk(sys_clk),
        .srst(srst),
        .d(pins_raw),
        .q(pins_s)
    );

    // Flush request is synchronous to this clock by the far side
    // no synchroniser needed
    assign flush_req_s = flush_request_n;

    always_comb begin
        prev_nxt = pins_s;
        trig_nxt = level_mode & PROG_TRIG_MASK;
        edge_hit = pins_s & ~prev_r;
        active = (edge_hit & ~trig_r) | (pins_s & trig_r);
        pend_nxt = pend_r | (active & irq_enable);
        vec_nxt = vec_r;
        vval_nxt = 1'b0;
        if (inta_pulse) begin
            vval_nxt = 1'b1;
            if (HOLD_CHECK_MASK[inta_line] && !pins_s[inta_line]) begin
                vec_nxt = DEFAULT_VECTOR;
            end else begin
                vec_nxt = inta_line;
            end
            // New edge in the same cycle wins over the clear
            pend_nxt[inta_line] = active[inta_line] & irq_enable[inta_line];
        end
        // Level lines stay pending while held high
        pend_nxt = pend_nxt & (~trig_r | pins_s);
        intr_nxt = |(pend_r & irq_enable);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_r <= '0;
            pend_r <= '0;
            trig_r <= TRIG_RESET;
            vec_r <= 4'h0;
            vval_r <= 1'b0;
            intr_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
            trig_r <= trig_nxt;
            vec_r <= vec_nxt;
            vval_r <= vval_nxt;
            intr_r <= intr_nxt;
        end
    end

    // Flush handshake
    always_comb begin
        fl_nxt = fl_r;
        fl_cnt_nxt = fl_cnt_r;
        start_nxt = 1'b0;
        case (fl_r)
            FL_IDLE: begin
                if (ioapic_enable && !flush_req_s) begin
                    fl_nxt = FL_FLUSH;
                    start_nxt = 1'b1;
                    fl_cnt_nxt = 8'(FLUSH_CYCLES);
                end
            end
            FL_FLUSH: begin
                if (fl_cnt_r != 8'h00) begin
                    fl_cnt_nxt = fl_cnt_r - 8'h01;
                end else if (flush_buffers_empty) begin
                    fl_nxt = FL_ACK;
                end
            end
            FL_ACK: begin
                if (flush_req_s || !ioapic_enable) begin
                    fl_nxt = FL_IDLE;
                end
            end
            default: fl_nxt = FL_IDLE;
        endcase
    end

    always_comb begin
        ack_n_nxt = ioapic_enable ? !(fl_nxt == FL_ACK) : gp_out_ack_alt;
        sel_n_nxt = ioapic_enable ? !(select_enable && pci_cycle_valid && in_range(pci_addr, ioapic_base, ioapic_limit))
                                  : gp_out_select_alt;
        tmr_nxt = ioapic_enable ? timer_timer_irq_out : gp_out_timer_alt;
        rout_n_nxt = ioapic_enable ? !(system_control_interrupt || smbus_irq) : gp_out_routed_alt;
        rtc_in_nxt = pins_s[RTC_LINE];
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fl_r <= FL_IDLE;
            fl_cnt_r <= 8'h00;
            start_r <= 1'b0;
            ack_n_r <= 1'b1;
            sel_n_r <= 1'b1;
            tmr_r <= 1'b0;
            rout_n_r <= 1'b1;
            rtc_in_r <= 1'b0;
        end else begin
            fl_r <= fl_nxt;
            fl_cnt_r <= fl_cnt_nxt;
            start_r <= start_nxt;
            ack_n_r <= ack_n_nxt;
            sel_n_r <= sel_n_nxt;
            tmr_r <= tmr_nxt;
            rout_n_r <= rout_n_nxt;
            rtc_in_r <= rtc_in_nxt;
        end
    end

    assign flush_done_ack_n = ack_n_r;
    assign ioapic_select_n = sel_n_r;
    assign timer_irq_out = tmr_r;
    assign routed_sci_smbus_irq_n = rout_n_r;
    assign flush_start = start_r;
    assign cpu_intr = intr_r;
    assign inta_vector = vec_r;
    assign inta_valid = vval_r;
    assign gp_in_request_alt = ioapic_enable ? 1'b1 : flush_req_s;
    assign gp_in_rtc_alt = (rtc_internal && rtc_gpi_select && !ioapic_enable) ? !rtc_in_r : 1'b0;
    assign rtc_pin_oe_n = !ioapic_enable;
    assign rtc_pin_out = !pend_r[RTC_LINE];
endmodule // legacy_irq_and_apic_handshake

/* File: verification/irq_front_assertions.sv */
// Assertion checker for the interrupt front end ports
`timescale 1ns/100ps
module irq_front_checker #(
    parameter int FLUSH_CYCLES = 4
) (
    input wire logic sys_clk, // Clock
    input wire logic srst, // Reset
    input wire logic ioapic_enable, // Controller used
    input wire logic flush_request_n, // Flush request
    input wire logic flush_done_ack_n, // Flush acknowledge
    input wire logic ioapic_select_n, // Chip select
    input wire logic timer_irq_out, // Timer out
    input wire logic routed_sci_smbus_irq_n, // Routed out
    input wire logic select_enable, // Decode enable
    input wire logic pci_cycle_valid, // Cycle valid
    input wire logic [31:0] pci_addr, // Address
    input wire logic [31:0] ioapic_base, // Range base
    input wire logic [31:0] ioapic_limit, // Range last
    input wire logic flush_start, // Flush start
    input wire logic timer_timer_irq_out, // Timer request
    input wire logic system_control_interrupt, // SYSTEM_CONTROL_INTERRUPT
    input wire logic smbus_irq, // SMBus interrupt
    input wire logic gp_out_timer_alt, // GP timer value
    input wire logic gp_out_routed_alt, // GP routed value
    input wire logic gp_in_request_alt // GP request read
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    int since_r;
    int since_nxt;
    always_comb begin
        since_nxt = (flush_start || since_r > 99) ? 0 : since_r + 1;
    end
    always_ff @(posedge sys_clk) begin
        since_r <= srst ? 100 : since_nxt;
    end
    a_reset_outputs_idle: assert property (disable iff (1'b0) srst |=> flush_done_ack_n && ioapic_select_n
        && routed_sci_smbus_irq_n && !timer_irq_out) else $error("outputs not idle after reset");
    a_ack_after_flush: assert property ($fell(flush_done_ack_n) |-> since_r >= FLUSH_CYCLES)
        else $error("acknowledge before flush time");
    a_start_on_request: assert property (flush_start |-> $past(!flush_request_n && ioapic_enable))
        else $error("flush start without request");
    a_ack_release: assert property (ioapic_enable && flush_request_n && !flush_done_ack_n |-> ##[1:2] flush_done_ack_n)
        else $error("acknowledge held after release");
    a_select_decode: assert property ($past(ioapic_enable) |-> !ioapic_select_n == $past(select_enable
        && pci_cycle_valid && pci_addr >= ioapic_base && pci_addr <= ioapic_limit)) else $error("select decode wrong");
    a_timer_follows: assert property (timer_irq_out == $past(ioapic_enable ? timer_timer_irq_out : gp_out_timer_alt))
        else $error("timer output wrong");
    a_routed_follows: assert property (routed_sci_smbus_irq_n == $past(ioapic_enable ?
        !(system_control_interrupt || smbus_irq) : gp_out_routed_alt)) else $error("routed output wrong");
    a_gp_request_read: assert property (gp_in_request_alt == (ioapic_enable ? 1'b1 : flush_request_n))
        else $error("general input wrong");
    c_flush: cover property (flush_start);
    c_select: cover property (!ioapic_select_n);
    c_timer: cover property (timer_irq_out);
endmodule // irq_front_checker
bind legacy_irq_and_apic_handshake irq_front_checker #(.FLUSH_CYCLES(FLUSH_CYCLES)) irq_front_checker_inst (.sys_clk,
    .srst, .ioapic_enable, .flush_request_n, .flush_done_ack_n, .ioapic_select_n, .timer_irq_out,
    .routed_sci_smbus_irq_n, .select_enable, .pci_cycle_valid, .pci_addr, .ioapic_base, .ioapic_limit, .flush_start,
    .timer_timer_irq_out, .system_control_interrupt, .smbus_irq, .gp_out_timer_alt, .gp_out_routed_alt, .gp_in_request_alt);

/* File: verification/ioapic_model.sv */
// External interrupt controller model: flush handshake then message
`timescale 1ns/100ps
module ioapic_model (
    input wire logic sys_clk, // Clock
    input wire logic go, // Start one delivery
    input wire logic flush_done_ack_n, // Acknowledge from block
    output logic flush_request_n, // Request to block
    output int msg_count // Messages sent
);
    initial begin
        flush_request_n = 1'b1;
        msg_count = 0;
    end
    always @(posedge sys_clk) begin
        if (go && flush_request_n) begin
            flush_request_n <= #1 1'b0;
        end else if (!flush_request_n && !flush_done_ack_n) begin
            msg_count <= #1 msg_count + 1;
            flush_request_n <= #1 1'b1;
        end
    end
endmodule // ioapic_model

/* File: verification/legacy_irq_and_apic_handshake_tb_top.sv */
// Self-checking bench for the interrupt front end
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module legacy_irq_and_apic_handshake_tb_top;
    import irq_front_pkg::*;
    logic sys_clk = 0, srst = 1, ioapic_enable = 1, flush_request_n, flush_done_ack_n, ioapic_select_n, timer_irq_out;
    logic routed_sci_smbus_irq_n, select_enable = 1, pci_cycle_valid = 0, flush_start, flush_buffers_empty = 1;
    logic [31:0] pci_addr = 32'h0, ioapic_base = 32'hfec00000, ioapic_limit = 32'hfec000ff;
    logic timer_timer_irq_out = 0, system_control_interrupt = 0, smbus_irq = 0, gp_out_ack_alt = 0, gp_out_select_alt = 0;
    logic gp_out_timer_alt = 0, gp_out_routed_alt = 0, gp_in_request_alt, gp_in_rtc_alt, rtc_gpi_select = 0;
    logic rtc_internal = 1, rtc_irq_in_n = 1, rtc_pin_out, rtc_pin_oe_n, keyboard_irq_in = 0, inta_pulse = 0;
    logic [NUM_IRQ-1:0] irq_in = '0, level_mode = '0, irq_enable = 16'hffff;
    logic [3:0] inta_line = 4'h0, inta_vector;
    logic cpu_intr, inta_valid, go = 0;
    int msg_count, n_mismatch = 0, samples_checked = 0, cyc = 0;
    legacy_irq_and_apic_handshake #(.FLUSH_CYCLES(2)) legacy_irq_and_apic_handshake_inst (.*);
    ioapic_model ioapic_model_inst (.sys_clk(sys_clk), .go(go), .flush_done_ack_n(flush_done_ack_n),
        .flush_request_n(flush_request_n), .msg_count(msg_count));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_intr();
        for (int k = 0; k < 20 && cpu_intr !== 1'b1; k++) tick(1);
        `CHK("cpu_intr", 1'b1, cpu_intr)
    endtask
    task automatic ack_intr(input logic [3:0] line, input logic [3:0] exp);
        inta_pulse = 1;
        inta_line = line;
        tick(1);
        inta_pulse = 0;
        `CHK("inta_valid", 1'b1, inta_valid)
        `CHK("inta_vector", exp, inta_vector)
        tick(3);
    endtask
    task automatic t_flush();
        go = 1;
        tick(1);
        go = 0;
        for (int k = 0; k < 40 && msg_count == 0; k++) tick(1);
        tick(3);
        `CHK("messages", 1, msg_count)
        `CHK("ack_idle", 1'b1, flush_done_ack_n)
    endtask
    task automatic t_pins();
        foreach (ioapic_limit[i]) if (i < 3) begin
            pci_cycle_valid = 1;
            pci_addr = ioapic_limit + i - 1;
            tick(1);
            `CHK("select", i == 2, ioapic_select_n)
        end
        pci_cycle_valid = 0;
        timer_timer_irq_out = 1;
        smbus_irq = 1;
        tick(2);
        `CHK("timer", 1'b1, timer_irq_out)
        `CHK("routed", 1'b0, routed_sci_smbus_irq_n)
        {ioapic_enable, gp_out_ack_alt, gp_out_select_alt, gp_out_routed_alt} = 4'h0;
        rtc_gpi_select = 1;
        tick(2);
        `CHK("gp_routed", 1'b0, routed_sci_smbus_irq_n)
        `CHK("gp_req_in", 1'b1, gp_in_request_alt)
        `CHK("gp_rtc_in", 1'b1, gp_in_rtc_alt)
        `CHK("gp_ack", 1'b0, flush_done_ack_n)
        `CHK("gp_sel", 1'b0, ioapic_select_n)
        `CHK("gp_timer", 1'b0, timer_irq_out)
        `CHK("gp_rtc_oe", 1'b1, rtc_pin_oe_n)
        {ioapic_enable, timer_timer_irq_out, smbus_irq} = 3'h4;
        rtc_gpi_select = 0;
        tick(2);
        `CHK("rtc_oe_on", 1'b0, rtc_pin_oe_n)
    endtask
    task automatic t_irqs();
        keyboard_irq_in = 1;
        wait_intr();
        ack_intr(4'h1, 4'h1);
        keyboard_irq_in = 0;
        irq_in[3] = 1;
        tick(6);
        irq_in[3] = 0;
        tick(4);
        ack_intr(4'h3, DEFAULT_VECTOR);
        rtc_irq_in_n = 0;
        wait_intr();
        ack_intr(4'h8, 4'h8);
        rtc_irq_in_n = 1;
        tick(4);
        rtc_irq_in_n = 0;
        tick(6);
        rtc_irq_in_n = 1;
        tick(4);
        ack_intr(4'h8, DEFAULT_VECTOR);
        level_mode[5] = 1;
        irq_in[5] = 1;
        wait_intr();
        ack_intr(4'h5, 4'h5);
        `CHK("level_again", 1'b1, cpu_intr)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        tick(10);
        `CHK("reset_ack", 1'b1, flush_done_ack_n)
        `CHK("reset_timer", 1'b0, timer_irq_out)
        srst = 0;
        tick(3);
        t_flush();
        t_pins();
        t_irqs();
        summarize();
    end
endmodule // legacy_irq_and_apic_handshake_tb_top
